// ### ccco_pkg.sv
// Shared constants and carriers for the call/clear/complement execution unit.
// Assumes a 10-bit program counter and 64 file registers.
package ccco_pkg;
  // ------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CCCO_OP_NONE = 3'h0,
    CCCO_OP_INDIRECT_CALL = 3'h1,
    CCCO_OP_CLEAR_WORK = 3'h2,
    CCCO_OP_CLEAR_FILE = 3'h3,
    CCCO_OP_INVERT_FILE = 3'h4,
    CCCO_OP_KICK_WATCHDOG = 3'h5
  } ccco_op_t;

  // ------------------------------------------------------------
  // Register offsets (APB byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] CCCO_ADDR_CMD = 8'h00;
  localparam logic [7:0] CCCO_ADDR_WORK = 8'h04;
  localparam logic [7:0] CCCO_ADDR_PAGE = 8'h08;
  localparam logic [7:0] CCCO_ADDR_PC = 8'h0C;
  localparam logic [7:0] CCCO_ADDR_STATUS = 8'h10;
  localparam logic [7:0] CCCO_ADDR_SP = 8'h14;
  localparam logic [7:0] CCCO_ADDR_WDOG = 8'h18;
  localparam logic [7:0] CCCO_ADDR_FILE = 8'h1C;
  localparam logic [7:0] CCCO_ADDR_STACK = 8'h20;

  // ------------------------------------------------------------
  // Command, status and watchdog word fields
  // ------------------------------------------------------------
  localparam int CCCO_CMD_OP_LSB = 0;
  localparam int CCCO_CMD_ADDR_LSB = 8;
  localparam int CCCO_CMD_DEST_BIT = 16;
  localparam int CCCO_STAT_ZERO_BIT = 0;
  localparam int CCCO_STAT_EXPIRY_BIT = 1;
  localparam int CCCO_STAT_SLEEP_BIT = 2;
  localparam int CCCO_STAT_BUSY_BIT = 3;
  localparam int CCCO_WDOG_PRESC_LSB = 8;
  localparam int CCCO_WDOG_ASSIGN_BIT = 16;

  // ------------------------------------------------------------
  // Reset values and cycle counts
  // ------------------------------------------------------------
  localparam logic [9:0] CCCO_PC_RESET = 10'h000;
  localparam logic [7:0] CCCO_BYTE_ZERO = 8'h00;
  localparam logic [1:0] CCCO_CALL_CYCLES = 2'h2;

  // Status flags carried together
  typedef struct packed {
    logic zeroFlag;
    logic watchdogExpiryN;
    logic sleepEnteredN;
  } ccco_status_t;

  // Zero test used by the file-invert flag update; the clears set the flag directly
  function automatic logic ccco_is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction
endpackage

// ### ccco_file_regs.sv
// File register bank of 64 bytes, one write port, one async read port.
// Assumes a single mclk domain and synchronous srst.
`timescale 1ns/1ps
`default_nettype none
module ccco_file_regs #(
  parameter int DEPTH = 64
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic wrEn,
  input wire logic [5:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [5:0] rdAddr,
  output logic [7:0] rdData
);
  import ccco_pkg::*;
  logic [7:0] mem [DEPTH];

  // Combinational read, needed in the same cycle as the write-back
  assign rdData = mem[rdAddr];

  // Storage, cleared on reset so reads are defined
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= CCCO_BYTE_ZERO;
      end
    end else if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end
endmodule
`default_nettype wire

// ### ccco_call_stack.sv
// Return address stack with a push port and a pointer.
// Assumes software never overflows it; the pointer wraps silently.
`timescale 1ns/1ps
`default_nettype none
module ccco_call_stack #(
  parameter int DEPTH = 8,
  parameter int PTRW = 3
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic push,
  input wire logic [9:0] pushData,
  input wire logic [PTRW-1:0] peekIdx,
  output logic [9:0] peekData,
  output logic [PTRW-1:0] stackPtr
);
  import ccco_pkg::*;
  logic [9:0] slots [DEPTH];
  logic [PTRW-1:0] ptr_r;
  logic [PTRW-1:0] ptr_nxt;

  assign stackPtr = ptr_r;
  assign peekData = slots[peekIdx];

  // Pointer advance on push
  always_comb begin
    ptr_nxt = ptr_r;
    if (push) begin
      ptr_nxt = ptr_r + PTRW'(1);
    end
  end

  // Slot written at current pointer, then pointer moves
  always_ff @(posedge mclk) begin
    if (srst) begin
      ptr_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        slots[i] <= CCCO_PC_RESET;
      end
    end else begin
      ptr_r <= ptr_nxt;
      if (push) begin
        slots[ptr_r] <= pushData;
      end
    end
  end
endmodule
`default_nettype wire

// ### ccco_exec.sv
// Execution unit for indirect call, clears, invert and watchdog service.
// Assumes an APB master on mclk; software writes a command word to start.
`timescale 1ns/1ps
`default_nettype none
module ccco_exec #(
  parameter int STACK_DEPTH = 8,
  parameter int STACK_PTRW = 3
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic watchdogTick,
  input wire logic prescalerTick,
  output ccco_pkg::ccco_status_t statusOut
);
  import ccco_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_CALL2 = 3'b100
  } ccco_state_t;

  // Architectural state and its next values
  ccco_state_t state_r, state_nxt;
  ccco_op_t op_r, op_nxt;
  logic [5:0] fAddr_r, fAddr_nxt;
  logic dest_r, dest_nxt;
  logic [7:0] work_r, work_nxt;
  logic [7:0] page_r, page_nxt;
  logic [9:0] pc_r, pc_nxt;
  ccco_status_t stat_r, stat_nxt;
  logic [7:0] wdog_r, wdog_nxt;
  logic [7:0] presc_r, presc_nxt;
  logic pscAssign_r, pscAssign_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  // ------------------------------------------------------------
  // Datapath nets
  // ------------------------------------------------------------
  // Strobes and data into the file bank and the stack
  logic fileWe;
  logic [7:0] fileWData;
  logic [7:0] fileRData;
  logic stkPush;
  logic [9:0] stkData;
  logic [9:0] stkPeek;
  logic [STACK_PTRW-1:0] stkPtr;
  logic [7:0] inverted;
  logic apbAccess;
  logic apbWrite;
  logic busy;

  // ------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------
  // One address serves both the operand read and the write-back
  ccco_file_regs u_file (
    .mclk(mclk),
    .srst(srst),
    .wrEn(fileWe),
    .wrAddr(fAddr_r),
    .wrData(fileWData),
    .rdAddr(fAddr_r),
    .rdData(fileRData)
  );

  // Peek index comes straight from the word address bits
  ccco_call_stack #(
    .DEPTH(STACK_DEPTH),
    .PTRW(STACK_PTRW)
  ) u_stack (
    .mclk(mclk),
    .srst(srst),
    .push(stkPush),
    .pushData(stkData),
    .peekIdx(paddr[STACK_PTRW+1:2]),
    .peekData(stkPeek),
    .stackPtr(stkPtr)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Every output is a flop, so the bus sees no decode glitches
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign statusOut = stat_r;

  // Access phase, answered one cycle later with pready
  assign apbAccess = psel && penable && !pready_r;
  assign apbWrite = apbAccess && pwrite;
  assign busy = state_r != ST_IDLE;

  // Complement of the addressed file byte, used by both destinations
  assign inverted = ~fileRData;

  // ------------------------------------------------------------
  // Instruction execution
  // ------------------------------------------------------------
  // Next-state of the core; commands during a busy call are dropped
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    fAddr_nxt = fAddr_r;
    dest_nxt = dest_r;
    work_nxt = work_r;
    page_nxt = page_r;
    pc_nxt = pc_r;
    stat_nxt = stat_r;
    wdog_nxt = wdog_r;
    presc_nxt = presc_r;
    pscAssign_nxt = pscAssign_r;
    fileWe = 1'b0;
    fileWData = CCCO_BYTE_ZERO;
    stkPush = 1'b0;
    stkData = pc_r + 10'h001;
    // Free-running counters; a kick below overrides the watchdog, and the prescaler only when assigned
    if (watchdogTick) begin
      wdog_nxt = wdog_r + 8'h01;
    end
    if (prescalerTick) begin
      presc_nxt = presc_r + 8'h01;
    end
    // A call keeps the unit busy for a second cycle
    unique case (state_r)
      ST_IDLE: begin
        if (apbWrite && paddr == CCCO_ADDR_CMD) begin
          op_nxt = ccco_op_t'(pwdata[CCCO_CMD_OP_LSB +: 3]);
          fAddr_nxt = pwdata[CCCO_CMD_ADDR_LSB +: 6];
          dest_nxt = pwdata[CCCO_CMD_DEST_BIT];
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // Non-call ops retire here and step the counter
        state_nxt = ST_IDLE;
        pc_nxt = pc_r + 10'h001;
        unique case (op_r)
          CCCO_OP_INDIRECT_CALL: begin
            stkPush = 1'b1;
            pc_nxt = pc_r;
            state_nxt = ST_CALL2;
          end
          CCCO_OP_CLEAR_WORK: begin
            work_nxt = CCCO_BYTE_ZERO;
            stat_nxt.zeroFlag = 1'b1;
          end
          CCCO_OP_CLEAR_FILE: begin
            fileWe = 1'b1;
            stat_nxt.zeroFlag = 1'b1;
          end
          CCCO_OP_INVERT_FILE: begin
            if (dest_r) begin
              fileWe = 1'b1;
              fileWData = inverted;
            end else begin
              work_nxt = inverted;
            end
            // Flag follows the result whatever the destination
            stat_nxt.zeroFlag = ccco_is_zero(inverted);
          end
          CCCO_OP_KICK_WATCHDOG: begin
            // Kick beats a tick landing in the same cycle
            wdog_nxt = CCCO_BYTE_ZERO;
            if (pscAssign_r) begin
              presc_nxt = CCCO_BYTE_ZERO;
            end
            stat_nxt.watchdogExpiryN = 1'b1;
            stat_nxt.sleepEnteredN = 1'b1;
          end
          default: begin
          end
        endcase
      end
      ST_CALL2: begin
        // Second cycle of the call: jump to {page[1:0], work}
        pc_nxt = {page_r[1:0], work_r};
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Software loads of operands, only when idle to keep ops atomic
    if (apbWrite && state_r == ST_IDLE) begin
      unique case (paddr)
        CCCO_ADDR_WORK: work_nxt = pwdata[7:0];
        CCCO_ADDR_PAGE: page_nxt = pwdata[7:0];
        CCCO_ADDR_PC: pc_nxt = pwdata[9:0];
        CCCO_ADDR_STATUS: begin
          stat_nxt.zeroFlag = pwdata[CCCO_STAT_ZERO_BIT];
          stat_nxt.watchdogExpiryN = pwdata[CCCO_STAT_EXPIRY_BIT];
          stat_nxt.sleepEnteredN = pwdata[CCCO_STAT_SLEEP_BIT];
        end
        CCCO_ADDR_WDOG: pscAssign_nxt = pwdata[CCCO_WDOG_ASSIGN_BIT];
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // APB read and answer
  // ------------------------------------------------------------
  // Read mux; unmapped addresses answer with pslverr
  always_comb begin
    prdata_nxt = prdata_r;
    pready_nxt = apbAccess;
    pslverr_nxt = 1'b0;
    if (apbAccess) begin
      // Unused bits read as zero
      prdata_nxt = 32'h0000_0000;
      // Stack window, one word per slot
      if (paddr >= CCCO_ADDR_STACK &&
          paddr < CCCO_ADDR_STACK + 8'(4 * STACK_DEPTH)) begin
        prdata_nxt[9:0] = stkPeek;
      end else begin
        unique case (paddr)
          CCCO_ADDR_CMD: prdata_nxt[CCCO_STAT_BUSY_BIT] = busy;
          CCCO_ADDR_WORK: prdata_nxt[7:0] = work_r;
          CCCO_ADDR_PAGE: prdata_nxt[7:0] = page_r;
          CCCO_ADDR_PC: prdata_nxt[9:0] = pc_r;
          CCCO_ADDR_STATUS: begin
            prdata_nxt[CCCO_STAT_ZERO_BIT] = stat_r.zeroFlag;
            prdata_nxt[CCCO_STAT_EXPIRY_BIT] = stat_r.watchdogExpiryN;
            prdata_nxt[CCCO_STAT_SLEEP_BIT] = stat_r.sleepEnteredN;
            prdata_nxt[CCCO_STAT_BUSY_BIT] = busy;
          end
          CCCO_ADDR_SP: prdata_nxt[STACK_PTRW-1:0] = stkPtr;
          CCCO_ADDR_WDOG: begin
            prdata_nxt[7:0] = wdog_r;
            prdata_nxt[CCCO_WDOG_PRESC_LSB +: 8] = presc_r;
            prdata_nxt[CCCO_WDOG_ASSIGN_BIT] = pscAssign_r;
          end
          CCCO_ADDR_FILE: prdata_nxt[7:0] = fileRData;
          default: pslverr_nxt = 1'b1;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Every register of the unit, reset to its power-up value
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      op_r <= CCCO_OP_NONE;
      fAddr_r <= 6'h00;
      dest_r <= 1'b0;
      work_r <= CCCO_BYTE_ZERO;
      page_r <= CCCO_BYTE_ZERO;
      pc_r <= CCCO_PC_RESET;
      stat_r <= '{zeroFlag: 1'b0, watchdogExpiryN: 1'b1,
                  sleepEnteredN: 1'b1};
      wdog_r <= CCCO_BYTE_ZERO;
      presc_r <= CCCO_BYTE_ZERO;
      pscAssign_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      fAddr_r <= fAddr_nxt;
      dest_r <= dest_nxt;
      work_r <= work_nxt;
      page_r <= page_nxt;
      pc_r <= pc_nxt;
      stat_r <= stat_nxt;
      wdog_r <= wdog_nxt;
      presc_r <= presc_nxt;
      pscAssign_r <= pscAssign_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end
endmodule
`default_nettype wire

// ### ccco_exec_props.sv
// Port checker for the execution unit.
// Assumes one mclk domain; bound to every unit instance.
`timescale 1ns/1ps
`default_nettype none
module ccco_exec_props
  import ccco_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter int STACK_PTRW = 3
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic watchdogTick,
  input wire logic prescalerTick,
  input wire ccco_pkg::ccco_status_t statusOut
);
  // ---------------------------------------------
  // Helpers and assertions
  // ---------------------------------------------
  logic take;
  logic cmdW;
  // Access taken, command write taken
  assign take = psel && penable && !pready;
  assign cmdW = take && pwrite && paddr == CCCO_ADDR_CMD;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  rdy_after_take_a: assert property (take |=> pready)
    else $error("no ready after a taken access");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  rdy_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  err_with_rdy_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  mapped_ok_a: assert property (pready && paddr[1:0] == 2'b00 &&
    paddr <= 8'h3C |-> !pslverr)
    else $error("error on a mapped word");
  clr_work_a: assert property (
    cmdW && pwdata[2:0] == CCCO_OP_CLEAR_WORK |-> ##2 statusOut.zeroFlag)
    else $error("zero flag not set by work clear");
  clr_file_a: assert property (
    cmdW && pwdata[2:0] == CCCO_OP_CLEAR_FILE |-> ##2 statusOut.zeroFlag)
    else $error("zero flag not set by file clear");
  kick_flags_a: assert property (cmdW &&
    pwdata[2:0] == CCCO_OP_KICK_WATCHDOG
    |-> ##2 statusOut.watchdogExpiryN && statusOut.sleepEnteredN)
    else $error("status flags not set by watchdog kick");
endmodule
bind ccco_exec ccco_exec_props #(
  .STACK_DEPTH(STACK_DEPTH), .STACK_PTRW(STACK_PTRW)
) u_props (
  .mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .watchdogTick(watchdogTick),
  .prescalerTick(prescalerTick), .statusOut(statusOut)
);
`default_nettype wire

// ### call_clear_complement_ops_tb_top.sv
// Self-checking bench for the execution unit over its register bus.
// Assumes the unit answers every access; no partner model is needed.
`timescale 1ns/1ps
`default_nettype none
module call_clear_complement_ops_tb_top;
  import ccco_pkg::*;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
  logic mclk, srst, psel, penable, pwrite, watchdogTick, prescalerTick;
  logic [7:0] paddr, lfsrR, w, pg;
  logic [31:0] pwdata, prdata, sp;
  logic [9:0] pc;
  logic [5:0] fa;
  logic pready, pslverr;
  ccco_status_t statusOut;
  int miscompares, checks, cycles;
  logic [32:0] expQ[$];
  logic [32:0] mskQ[$];
  ccco_exec #(.STACK_DEPTH(8), .STACK_PTRW(3)) dut (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .watchdogTick(watchdogTick),
    .prescalerTick(prescalerTick), .statusOut(statusOut)
  );
  // ---------------------------------------------
  // Clock, timeout, result monitor
  // ---------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Oldest note is matched against each answer
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
    if (pready === 1'b1 && expQ.size() > 0) begin
      `CHK({pslverr, prdata} & mskQ[0], expQ[0] & mskQ[0])
      void'(expQ.pop_front());
      void'(mskQ.pop_front());
    end
  end
  // ---------------------------------------------
  // Stimulus tasks
  // ---------------------------------------------
  function automatic logic [7:0] rnd();
    lfsrR = {lfsrR[6:0], lfsrR[7] ^ lfsrR[5] ^ lfsrR[4] ^ lfsrR[3]};
    return lfsrR;
  endfunction
  // Setup then access; request held until ready is sampled
  task automatic acc(input logic [7:0] a, input logic wr_,
                     input logic [31:0] d, input logic [32:0] e,
                     input logic [32:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr_;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(a, 1'b1, d, 33'h0, 33'h1_0000_0000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    acc(a, 1'b0, 32'h0, {1'b0, e}, {1'b1, m});
  endtask
  task automatic cmd(input ccco_op_t op, input logic [5:0] f, input logic d);
    wr(CCCO_ADDR_CMD, {15'h0, d, 2'h0, f, 5'h0, op});
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    {srst, psel, penable, pwrite, watchdogTick, prescalerTick} = 6'h20;
    {paddr, pwdata, sp} = '0;
    lfsrR = 8'h5A;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rd(CCCO_ADDR_PC, 32'h0, 32'h0000_03FF);
    rd(CCCO_ADDR_SP, 32'h0, 32'h0000_0007);
    rd(CCCO_ADDR_STATUS, 32'h6, 32'h0000_000F);
    acc(8'h40, 1'b0, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
    $display("reset test done");
    wr(CCCO_ADDR_WORK, {24'h0, rnd()});
    wr(CCCO_ADDR_STATUS, 32'h0);
    cmd(CCCO_OP_CLEAR_WORK, 6'h0, 1'b0);
    rd(CCCO_ADDR_WORK, 32'h0, 32'h0000_00FF);
    rd(CCCO_ADDR_STATUS, 32'h1, 32'h0000_000F);
    `CHK(statusOut, 3'b100)
    $display("work clear test done");
    // Clear, invert back to file, invert into work
    repeat (3) begin
      fa = 6'(rnd());
      cmd(CCCO_OP_CLEAR_FILE, fa, 1'b0);
      rd(CCCO_ADDR_FILE, 32'h0, 32'h0000_00FF);
      rd(CCCO_ADDR_STATUS, 32'h1, 32'h1);
      cmd(CCCO_OP_INVERT_FILE, fa, 1'b1);
      rd(CCCO_ADDR_FILE, 32'h0000_00FF, 32'h0000_00FF);
      rd(CCCO_ADDR_STATUS, 32'h0, 32'h1);
      wr(CCCO_ADDR_WORK, {24'h0, rnd()});
      cmd(CCCO_OP_INVERT_FILE, fa, 1'b0);
      rd(CCCO_ADDR_WORK, 32'h0, 32'h0000_00FF);
      rd(CCCO_ADDR_FILE, 32'h0000_00FF, 32'h0000_00FF);
      rd(CCCO_ADDR_STATUS, 32'h1, 32'h1);
    end
    $display("file op test done");
    // Indirect call from random places, stack pointer tracked
    repeat (2) begin
      pc = {2'(rnd()), rnd()};
      pg = rnd();
      w = rnd();
      wr(CCCO_ADDR_PC, {22'h0, pc});
      wr(CCCO_ADDR_PAGE, {24'h0, pg});
      wr(CCCO_ADDR_WORK, {24'h0, w});
      cmd(CCCO_OP_INDIRECT_CALL, 6'h0, 1'b0);
      rd(CCCO_ADDR_PC, {22'h0, pg[1:0], w}, 32'h0000_03FF);
      rd(CCCO_ADDR_SP, sp + 1, 32'h0000_0007);
      rd(CCCO_ADDR_STACK + 8'(4 * sp), {22'h0, pc + 10'h1}, 32'h3FF);
      sp++;
    end
    $display("call test done");
    // Kick with prescaler assigned, then unassigned
    for (int asg = 1; asg >= 0; asg--) begin
      wr(CCCO_ADDR_WDOG, {15'h0, 1'(asg), 16'h0});
      wr(CCCO_ADDR_STATUS, 32'h0);
      repeat (3) begin
        {watchdogTick, prescalerTick} <= 2'h3;
        @(posedge mclk);
        {watchdogTick, prescalerTick} <= 2'h0;
        @(posedge mclk);
      end
      rd(CCCO_ADDR_WDOG, {15'h0, 1'(asg), 16'h0303}, 32'h1_FFFF);
      cmd(CCCO_OP_KICK_WATCHDOG, 6'h0, 1'b0);
      rd(CCCO_ADDR_WDOG, {15'h0, 1'(asg), (asg ? 16'h0 : 16'h0300)},
         32'h1_FFFF);
      rd(CCCO_ADDR_STATUS, 32'h6, 32'h0000_000E);
      `CHK(statusOut, 3'b011)
    end
    $display("watchdog test done");
    repeat (4) @(posedge mclk);
    close_out();
  end
endmodule
`default_nettype wire
